// file: include/rbdc_defines.svh
// rx burst dma coalescer: offsets, field positions, reset values, timing counts
// assumes a 10 MHz device clock and 16-bit register data
`ifndef RBDC_DEFINES_SVH
`define RBDC_DEFINES_SVH

// ==========================================================
// register offsets
`define RBDC_OFF_RX_CONFIG 16'h0102
`define RBDC_OFF_RX_CONTROL 16'h0104
`define RBDC_OFF_BUF_CONFIG 16'h010A
`define RBDC_OFF_BUF_EVENT 16'h012C
`define RBDC_OFF_DMA_START 16'h0026
`define RBDC_OFF_DMA_FCOUNT 16'h0028
`define RBDC_OFF_DMA_BCOUNT 16'h002A

// ==========================================================
// field positions
`define RBDC_CFG_COALESCE_EN 7
`define RBDC_CFG_GOOD_IRQ_EN 8
`define RBDC_CFG_DMA_ONLY 9
`define RBDC_CFG_AUTO_SWITCH 10
`define RBDC_CTL_ACCEPT_GOOD 8
`define RBDC_BUF_DMA_IRQ_EN 7
`define RBDC_BUF_EARLY128_EN 11
`define RBDC_BUF_DEST_SEEN_EN 15
`define RBDC_EVT_DMA_FRAME 7

// ==========================================================
// reset values
`define RBDC_RST_RX_CONFIG 16'h0000
`define RBDC_RST_RX_CONTROL 16'h0000
`define RBDC_RST_BUF_CONFIG 16'h0000

// ==========================================================
// timing
`define RBDC_CLK_HZ 10000000
`define RBDC_GAP_MIN_NS 9600
`define RBDC_GAP_B2B_MAX_NS 52000
`define RBDC_GAP_CONT_MAX_MS 52
`define RBDC_GAP_MIN_CYC ((`RBDC_GAP_MIN_NS * (`RBDC_CLK_HZ / 1000000) + 999) / 1000)
`define RBDC_GAP_B2B_MAX_CYC ((`RBDC_GAP_B2B_MAX_NS * (`RBDC_CLK_HZ / 1000000)) / 1000)
`define RBDC_GAP_CONT_MAX_CYC (`RBDC_GAP_CONT_MAX_MS * (`RBDC_CLK_HZ / 1000))
`define RBDC_BURST_FRAMES 8

`endif

// file: include/rbdc_pkg.sv
// rx burst dma coalescer: shared types
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package rbdc_pkg;
   // ==========================================================
   // burst state, one-hot
   typedef enum logic [2:0] {
      RBDC_IDLE  = 3'b001,
      RBDC_ARMED = 3'b010,
      RBDC_BURST = 3'b100
   } rbdc_state_t;

   typedef logic [19:0] rbdc_gap_t;
   typedef logic [3:0] rbdc_cycle_cnt_t;
endpackage : rbdc_pkg

`default_nettype wire

// file: rtl/rbdc_gap_timer.sv
// rx burst dma coalescer: inter-frame gap counter
// assumes frame end and frame start strobes are one-cycle pulses on clk
`default_nettype none

module rbdc_gap_timer (
   input wire logic clk, // device clock
   input wire logic rst_n, // sync reset, active low
   input wire logic frameEnd, // end of a received frame
   output logic [19:0] gapCount // cycles since last frame end
);
   // ==========================================================
   // saturating count, starts saturated so no gap looks short
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gapCount <= 20'hFFFFF;
      end else if (frameEnd) begin
         gapCount <= 20'h00000;
      end else if (gapCount != 20'hFFFFF) begin
         gapCount <= gapCount + 20'h00001;
      end
   end
endmodule : rbdc_gap_timer

`default_nettype wire

// file: rtl/rbdc_top.sv
// rx burst dma coalescer: burst grouping, dma mode select, dma registers
// assumes one-cycle frame and dma strobes, 16-bit register port on clk
`include "rbdc_defines.svh"
`default_nettype none

module rbdc_top #(
   parameter int unsigned CONT_MAX_CYC = `RBDC_GAP_CONT_MAX_CYC // 52 ms gap in cycles
) (
   input wire logic clk, // device clock 10 MHz
   input wire logic rst_n, // sync reset, active low
   input wire logic [15:0] regAddr, // register offset
   input wire logic regWrite, // register write strobe
   input wire logic regRead, // register read strobe
   input wire logic [15:0] regWdata, // write data
   output logic [15:0] regRdata, // read data, one cycle after strobe
   input wire logic frameStart, // receive frame start pulse
   input wire logic frameEnd, // receive frame end pulse
   input wire logic frameGood, // legal length and crc ok, with end
   input wire logic frameDaPass, // destination filter passed, with end
   input wire logic dmaFrameDone, // one frame moved to host memory
   input wire logic [15:0] dmaFrameAddr, // host offset of that frame
   input wire logic [15:0] dmaFrameBytes, // bytes of that frame
   input wire logic dmaBusy, // dma frame transfer in progress
   input wire logic autoSwitchNeed, // buffer short, auto switch wanted
   input wire logic eventsPending, // event queue not yet serviced
   output logic dmaActive, // slave receive dma mode
   output logic burstActive, // burst cycles running
   output logic goodFrameIrq, // good frame event pulse
   output logic dmaFrameIrq // dma frame event pulse
);
   // ==========================================================
   // configuration registers
   logic [15:0] rxConfig_reg;
   logic [15:0] rxControl_reg;
   logic [15:0] bufConfig_reg;
   logic [15:0] dmaStart_reg;
   logic [15:0] dmaFrameCount_reg;
   logic [15:0] dmaByteCount_reg;
   logic dmaFrameFlag_reg;
   logic [15:0] committed_reg;
   logic readPhase_reg;
   logic readZero_reg;
   rbdc_pkg::rbdc_state_t state_reg;
   rbdc_pkg::rbdc_cycle_cnt_t cycleFrames_reg;
   logic [15:0] cycleBytes_reg;
   logic [15:0] cycleStart_reg;
   rbdc_pkg::rbdc_gap_t gapLatched_reg;
   rbdc_pkg::rbdc_gap_t gapCount;

   logic dmaOnly;
   logic autoSwitch;
   logic anyDma;
   logic coalesceOn;
   logic frameOk;
   logic backToBack;
   logic contOk;
   logic armedTimeout;
   logic burstTimeout;
   logic heldRelease;
   logic burstEnter;
   logic burstExit;
   logic cycleClose;
   logic inBurst;
   logic fcountRead;
   logic [15:0] addFrames;
   logic [15:0] subFrames;
   logic [15:0] dmaFrameCount_next;
   rbdc_pkg::rbdc_cycle_cnt_t cycleInclusive;
   logic [15:0] cycleBytesInclusive;
   logic [15:0] cycleStartInclusive;

   assign dmaOnly = rxConfig_reg[`RBDC_CFG_DMA_ONLY];
   assign autoSwitch = rxConfig_reg[`RBDC_CFG_AUTO_SWITCH];
   assign anyDma = dmaOnly | autoSwitch;
   assign coalesceOn = rxConfig_reg[`RBDC_CFG_COALESCE_EN] & anyDma;
   assign inBurst = (state_reg == rbdc_pkg::RBDC_BURST);
   assign burstActive = inBurst;

   // ==========================================================
   // gap measurement
   // own clock gap count
   rbdc_gap_timer u_gap (
      .clk(clk),
      .rst_n(rst_n),
      .frameEnd(frameEnd),
      .gapCount(gapCount)
   );

   // latch the gap seen at the start of each frame
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gapLatched_reg <= 20'hFFFFF;
      end else if (frameStart) begin
         gapLatched_reg <= gapCount;
      end
   end

   assign backToBack = (gapLatched_reg >= 20'(`RBDC_GAP_MIN_CYC))
      && (gapLatched_reg <= 20'(`RBDC_GAP_B2B_MAX_CYC));
   assign contOk = (gapLatched_reg < 20'(CONT_MAX_CYC));
   assign armedTimeout = (gapCount > 20'(`RBDC_GAP_B2B_MAX_CYC));
   assign burstTimeout = (gapCount >= 20'(CONT_MAX_CYC));
   assign frameOk = frameEnd & frameGood & frameDaPass & rxControl_reg[`RBDC_CTL_ACCEPT_GOOD];

   // ==========================================================
   // burst sequencing
   assign burstEnter = (state_reg == rbdc_pkg::RBDC_ARMED) & frameOk & backToBack & coalesceOn;
   assign heldRelease = (state_reg == rbdc_pkg::RBDC_ARMED) & !burstEnter
      & (frameEnd | armedTimeout | !coalesceOn);
   assign burstExit = inBurst & ((frameEnd & !(frameOk & contOk)) | burstTimeout | !coalesceOn);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= rbdc_pkg::RBDC_IDLE;
      end else begin
         case (state_reg)
            rbdc_pkg::RBDC_IDLE: begin
               if (coalesceOn && frameOk) begin
                  state_reg <= rbdc_pkg::RBDC_ARMED;
               end
            end
            rbdc_pkg::RBDC_ARMED: begin
               if (burstEnter) begin
                  state_reg <= rbdc_pkg::RBDC_BURST;
               end else if (heldRelease && !(frameOk && coalesceOn)) begin
                  state_reg <= rbdc_pkg::RBDC_IDLE;
               end
            end
            rbdc_pkg::RBDC_BURST: begin
               if (burstExit) begin
                  state_reg <= rbdc_pkg::RBDC_IDLE;
               end
            end
            default: begin
               state_reg <= rbdc_pkg::RBDC_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // burst cycle accumulation
   // close cycle at eighth frame
   assign cycleClose = inBurst & ((dmaFrameDone
      & (cycleFrames_reg == 4'(`RBDC_BURST_FRAMES - 1))) | burstExit);
   assign cycleInclusive = cycleFrames_reg + {3'h0, dmaFrameDone};
   assign cycleBytesInclusive = dmaFrameDone ? cycleBytes_reg + dmaFrameBytes : cycleBytes_reg;
   assign cycleStartInclusive = (dmaFrameDone && cycleFrames_reg == 4'h0) ? dmaFrameAddr
      : cycleStart_reg;

   always_ff @(posedge clk) begin
      if (!rst_n || cycleClose || !inBurst) begin
         cycleFrames_reg <= 4'h0;
         cycleBytes_reg <= 16'h0000;
         cycleStart_reg <= 16'h0000;
      end else if (dmaFrameDone) begin
         cycleFrames_reg <= cycleInclusive;
         cycleBytes_reg <= cycleBytesInclusive;
         cycleStart_reg <= cycleStartInclusive;
      end
   end

   // ==========================================================
   // interrupt pulses
   // held irq only on release
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         goodFrameIrq <= 1'b0;
         dmaFrameIrq <= 1'b0;
      end else begin
         goodFrameIrq <= rxConfig_reg[`RBDC_CFG_GOOD_IRQ_EN] & (heldRelease | burstExit
            | (frameOk & (state_reg == rbdc_pkg::RBDC_IDLE) & !coalesceOn & !dmaOnly));
         dmaFrameIrq <= bufConfig_reg[`RBDC_BUF_DMA_IRQ_EN] & anyDma
            & (cycleClose | (dmaFrameDone & !inBurst));
      end
   end

   // ==========================================================
   // dma result registers
   // commit then release on reads
   assign fcountRead = regRead & (regAddr == `RBDC_OFF_DMA_FCOUNT);
   assign subFrames = (fcountRead && readPhase_reg) ? committed_reg : 16'h0000;
   assign addFrames = inBurst ? (cycleClose ? {12'h000, cycleInclusive} : 16'h0000)
      : {15'h0000, dmaFrameDone};
   assign dmaFrameCount_next = dmaFrameCount_reg + addFrames - subFrames;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dmaStart_reg <= 16'h0000;
         dmaByteCount_reg <= 16'h0000;
         dmaFrameCount_reg <= 16'h0000;
      end else begin
         dmaFrameCount_reg <= dmaFrameCount_next;
         if (inBurst && cycleClose && cycleInclusive != 4'h0) begin
            dmaStart_reg <= cycleStartInclusive;
            dmaByteCount_reg <= cycleBytesInclusive;
         end else if (!inBurst && dmaFrameDone) begin
            dmaStart_reg <= dmaFrameAddr;
            dmaByteCount_reg <= dmaFrameBytes;
         end
      end
   end

   // commit window and zero-read tracking
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         committed_reg <= 16'h0000;
         readPhase_reg <= 1'b0;
         readZero_reg <= 1'b0;
      end else begin
         if (fcountRead) begin
            readPhase_reg <= !readPhase_reg;
            if (!readPhase_reg) begin
               committed_reg <= dmaFrameCount_reg;
            end
         end
         if (addFrames != 16'h0000) begin
            readZero_reg <= 1'b0;
         end else if (fcountRead && dmaFrameCount_reg == 16'h0000) begin
            readZero_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dmaFrameFlag_reg <= 1'b0;
      end else if (inBurst ? cycleClose
                  : (dmaFrameCount_reg == 16'h0000 && dmaFrameCount_next != 16'h0000)) begin
         dmaFrameFlag_reg <= 1'b1;
      end else if (dmaFrameCount_next == 16'h0000) begin
         dmaFrameFlag_reg <= 1'b0;
      end
   end

   // ==========================================================
   // dma mode select
   // no mode, no dma
   always_ff @(posedge clk) begin
      if (!rst_n || !anyDma) begin
         dmaActive <= 1'b0;
      end else if (dmaOnly || burstEnter || inBurst || autoSwitchNeed) begin
         dmaActive <= 1'b1;
      end else if (!eventsPending && readZero_reg && !dmaBusy) begin
         dmaActive <= 1'b0;
      end
   end

   // ==========================================================
   // register port
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rxConfig_reg <= `RBDC_RST_RX_CONFIG;
         rxControl_reg <= `RBDC_RST_RX_CONTROL;
         bufConfig_reg <= `RBDC_RST_BUF_CONFIG;
      end else if (regWrite) begin
         case (regAddr)
            `RBDC_OFF_RX_CONFIG: rxConfig_reg <= regWdata;
            `RBDC_OFF_RX_CONTROL: rxControl_reg <= regWdata;
            `RBDC_OFF_BUF_CONFIG: bufConfig_reg <= regWdata;
            default: begin
            end
         endcase
      end
   end

   // read data, unmapped offsets read zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regRdata <= 16'h0000;
      end else if (regRead) begin
         case (regAddr)
            `RBDC_OFF_RX_CONFIG: regRdata <= rxConfig_reg;
            `RBDC_OFF_RX_CONTROL: regRdata <= rxControl_reg;
            `RBDC_OFF_BUF_CONFIG: regRdata <= bufConfig_reg;
            `RBDC_OFF_BUF_EVENT: regRdata <= {8'h00, dmaFrameFlag_reg, 7'h00};
            `RBDC_OFF_DMA_START: regRdata <= dmaStart_reg;
            `RBDC_OFF_DMA_FCOUNT: regRdata <= dmaFrameCount_reg;
            `RBDC_OFF_DMA_BCOUNT: regRdata <= dmaByteCount_reg;
            default: regRdata <= 16'h0000;
         endcase
      end
   end
   // software duty, bits only stored here
endmodule : rbdc_top

`default_nettype wire

// file: tb/rbdc_top_sva.sv
// rbdc checker: port-level timing of burst, irq and dma mode
// assumes rbdc_top ports and offsets of rbdc_defines.svh
`include "rbdc_defines.svh"
`default_nettype none

module rbdc_top_sva #(
   parameter int unsigned CONT_MAX_CYC = `RBDC_GAP_CONT_MAX_CYC // continuation gap limit
) (
   input wire logic clk, // device clock
   input wire logic rst_n, // sync reset
   input wire logic [15:0] regAddr, // offset
   input wire logic regWrite, // write strobe
   input wire logic regRead, // read strobe
   input wire logic [15:0] regWdata, // write data
   input wire logic [15:0] regRdata, // read data
   input wire logic frameStart, // frame start
   input wire logic frameEnd, // frame end
   input wire logic frameGood, // frame good
   input wire logic frameDaPass, // filter passed
   input wire logic dmaFrameDone, // frame moved
   input wire logic [15:0] dmaFrameAddr, // frame offset
   input wire logic [15:0] dmaFrameBytes, // frame bytes
   input wire logic dmaBusy, // dma running
   input wire logic autoSwitchNeed, // switch wanted
   input wire logic eventsPending, // events open
   input wire logic dmaActive, // slave dma
   input wire logic burstActive, // burst running
   input wire logic goodFrameIrq, // good irq
   input wire logic dmaFrameIrq // dma irq
);
   logic [15:0] cfg_reg;
   logic [2:0] doneCnt_reg;

   // ========================================
   // helper state
   // shadow of rx config writes
   always_ff @(posedge clk) begin
      if (!rst_n) cfg_reg <= 16'h0000;
      else if (regWrite && regAddr == `RBDC_OFF_RX_CONFIG) cfg_reg <= regWdata;
   end
   // frames moved in this burst, modulo eight
   always_ff @(posedge clk) begin
      if (!rst_n || !burstActive) doneCnt_reg <= 3'h0;
      else if (dmaFrameDone) doneCnt_reg <= doneCnt_reg + 3'h1;
   end

   // ========================================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_good_irq_pulse:
      assert property (goodFrameIrq |=> !goodFrameIrq) else $error("good irq too long");
   chk_dma_irq_pulse:
      assert property (dmaFrameIrq |=> !dmaFrameIrq) else $error("dma irq too long");
   chk_no_mode_burst:
      assert property (cfg_reg[10:9] == 2'b00 && $stable(cfg_reg[10:9]) |-> !$rose(burstActive))
      else $error("burst without dma mode");
   chk_bad_frame_exit:
      assert property (burstActive && frameEnd && !frameGood
         |=> goodFrameIrq && dmaFrameIrq && !burstActive) else $error("bad exit");
   chk_bad_no_start:
      assert property (!burstActive && frameEnd && !(frameGood && frameDaPass) |=> !burstActive)
      else $error("burst on bad frame");
   chk_cycle_close_irq:
      assert property (burstActive && dmaFrameDone && doneCnt_reg == 3'h7 |=> dmaFrameIrq)
      else $error("no irq at cycle end");
   chk_burst_irq_cause:
      assert property (burstActive && $past(burstActive) && dmaFrameIrq
         |-> $past(dmaFrameDone) && $past(doneCnt_reg) == 3'h7) else $error("early dma irq");
   chk_dma_hold_busy:
      assert property (dmaActive && (dmaBusy || eventsPending) |=> dmaActive)
      else $error("dma left early");
   chk_burst_in_dma:
      assert property (burstActive && $past(burstActive) |-> dmaActive)
      else $error("burst outside dma");
endmodule : rbdc_top_sva

bind rbdc_top rbdc_top_sva #(.CONT_MAX_CYC(CONT_MAX_CYC)) u_rbdc_top_sva (.clk, .rst_n,
   .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .frameStart, .frameEnd, .frameGood,
   .frameDaPass, .dmaFrameDone, .dmaFrameAddr, .dmaFrameBytes, .dmaBusy, .autoSwitchNeed,
   .eventsPending, .dmaActive, .burstActive, .goodFrameIrq, .dmaFrameIrq);

`default_nettype wire

// file: tb/rbdc_dma_host.sv
// rbdc partner: system dma moving one frame per request
// assumes requests only matter while the device is in slave dma
`default_nettype none

module rbdc_dma_host (
   input wire logic clk, // device clock
   input wire logic rst_n, // sync reset
   input wire logic dmaActive, // device in slave dma
   input wire logic go, // move one frame
   input wire logic slow, // stretch transfer
   output logic dmaBusy, // transfer running
   output logic dmaFrameDone, // frame moved
   output logic [15:0] dmaFrameAddr, // frame offset
   output logic [15:0] dmaFrameBytes // frame bytes
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] left_reg;
   logic [15:0] cur_reg;

   // ========================================
   // transfer engine
   // busy while moving
   always_ff @(posedge clk) begin
      dmaFrameDone <= 1'b0;
      if (!rst_n) begin
         left_reg <= 4'h0;
         cur_reg <= 16'h0000;
         dmaBusy <= 1'b0;
      end else if (go && dmaActive && !dmaBusy) begin
         dmaBusy <= 1'b1;
         left_reg <= slow ? 4'h8 : 4'h1;
      end else if (dmaBusy && left_reg != 4'h0) begin
         left_reg <= left_reg - 4'h1;
      end else if (dmaBusy) begin
         dmaBusy <= 1'b0;
         dmaFrameDone <= 1'b1;
      end
      if (dmaFrameDone) cur_reg <= cur_reg + 16'h0040;
   end
   // frame data only valid with done, inverted otherwise
   assign dmaFrameAddr = dmaFrameDone ? cur_reg : ~cur_reg;
   assign dmaFrameBytes = dmaFrameDone ? 16'h0040 : 16'hFFBF;
endmodule : rbdc_dma_host

`default_nettype wire

// file: tb/rbdc_tb_top.sv
// rbdc testbench: register, frame and dma sequences with checks
// assumes rbdc_top, rbdc_dma_host and the bound checker
`include "rbdc_defines.svh"
`default_nettype none

module rbdc_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, go = 1'b0, slow = 1'b0;
   logic [15:0] regAddr = 16'h0000, regWdata = 16'h0000, regRdata, dmaFrameAddr, dmaFrameBytes;
   logic frameStart = 1'b0, frameEnd = 1'b0, frameGood = 1'b0, frameDaPass = 1'b0;
   logic autoSwitchNeed = 1'b0, eventsPending = 1'b0;
   logic dmaFrameDone, dmaBusy, dmaActive, burstActive, goodFrameIrq, dmaFrameIrq;
   int errors = 0, n_checks = 0, nGood = 0, nDma = 0, g, d;

   rbdc_top #(.CONT_MAX_CYC(2000)) u_rbdc_top (.clk, .rst_n, .regAddr, .regWrite, .regRead,
      .regWdata, .regRdata, .frameStart, .frameEnd, .frameGood, .frameDaPass, .dmaFrameDone,
      .dmaFrameAddr, .dmaFrameBytes, .dmaBusy, .autoSwitchNeed, .eventsPending, .dmaActive,
      .burstActive, .goodFrameIrq, .dmaFrameIrq);
   rbdc_dma_host u_rbdc_dma_host (.clk, .rst_n, .dmaActive, .go, .slow, .dmaBusy,
      .dmaFrameDone, .dmaFrameAddr, .dmaFrameBytes);

   // ========================================
   // clock and irq pulse counting
   always #50 clk = ~clk;
   // count irq pulses away from the launching edge
   always @(negedge clk) begin
      if (goodFrameIrq === 1'b1) nGood++;
      if (dmaFrameIrq === 1'b1) nDma++;
   end

   // ========================================
   // tasks
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask : tick
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   function automatic logic sig(input int k);
      case (k)
         0: return dmaFrameDone;
         1: return dmaActive;
         default: return !dmaActive;
      endcase
   endfunction : sig
   task automatic waitOn(input int k, input int n);
      for (int i = 0; i < n; i++) begin
         if (sig(k) === 1'b1) return;
         tick(1);
      end
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      summarize();
   endtask : waitOn
   task automatic wr(input logic [15:0] a, input logic [15:0] v);
      regAddr = a;
      regWdata = v;
      regWrite = 1'b1;
      tick(1);
      regWrite = 1'b0;
      tick(1);
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      regAddr = a;
      regRead = 1'b1;
      tick(1);
      regRead = 1'b0;
      chk(regRdata, exp);
      tick(1);
   endtask : rd
   task automatic fr(input int gap, input logic good);
      tick(gap);
      frameStart = 1'b1;
      tick(1);
      frameStart = 1'b0;
      frameEnd = 1'b1;
      frameGood = good;
      frameDaPass = 1'b1;
      tick(1);
      frameEnd = 1'b0;
   endtask : fr
   task automatic mv(input int n, input logic s);
      slow = s;
      repeat (n) begin
         go = 1'b1;
         tick(1);
         go = 1'b0;
         waitOn(0, 40);
      end
   endtask : mv

   // ========================================
   // main sequence
   initial begin
      tick(4);
      rst_n = 1'b1;
      tick(1);
      rd(`RBDC_OFF_RX_CONFIG, 16'h0000);
      rd(`RBDC_OFF_RX_CONTROL, 16'h0000);
      rd(`RBDC_OFF_BUF_CONFIG, 16'h0000);
      rd(16'h0200, 16'h0000);
      $display("test reset values done");
      wr(`RBDC_OFF_RX_CONFIG, 16'h0180);
      wr(`RBDC_OFF_RX_CONTROL, 16'h0100);
      g = nGood;
      fr(150, 1'b1);
      fr(150, 1'b1);
      tick(2);
      chk({15'h0000, burstActive}, 16'h0000);
      chk({15'h0000, dmaActive}, 16'h0000);
      chk(16'(nGood - g), 16'h0002);
      $display("test no dma mode done");
      wr(`RBDC_OFF_RX_CONFIG, 16'h0380);
      wr(`RBDC_OFF_BUF_CONFIG, 16'h0080);
      rd(`RBDC_OFF_RX_CONFIG, 16'h0380);
      g = nGood;
      d = nDma;
      fr(150, 1'b1);
      fr(150, 1'b1);
      tick(2);
      chk({15'h0000, burstActive}, 16'h0001);
      mv(4, 1'b0);
      mv(4, 1'b1);
      tick(2);
      chk(16'(nGood - g), 16'h0000);
      chk(16'(nDma - d), 16'h0001);
      rd(`RBDC_OFF_DMA_FCOUNT, 16'h0008);
      rd(`RBDC_OFF_DMA_BCOUNT, 16'h0200);
      rd(`RBDC_OFF_BUF_EVENT, 16'h0080);
      rd(`RBDC_OFF_BUF_EVENT, 16'h0080);
      rd(`RBDC_OFF_DMA_FCOUNT, 16'h0008);
      rd(`RBDC_OFF_DMA_FCOUNT, 16'h0000);
      rd(`RBDC_OFF_BUF_EVENT, 16'h0000);
      wr(`RBDC_OFF_DMA_FCOUNT, 16'hFFFF);
      rd(`RBDC_OFF_DMA_FCOUNT, 16'h0000);
      g = nGood;
      d = nDma;
      fr(150, 1'b0);
      tick(2);
      chk(16'({4'(nGood - g), 4'(nDma - d)}), 16'h0011);
      $display("test burst and bad exit done");
      fr(150, 1'b1);
      fr(150, 1'b1);
      g = nGood;
      d = nDma;
      tick(2100);
      chk({15'h0000, burstActive}, 16'h0000);
      chk(16'({4'(nGood - g), 4'(nDma - d)}), 16'h0011);
      $display("test gap exit done");
      // short gap: held frame released, second frame held, then timed out
      g = nGood;
      fr(150, 1'b1);
      fr(50, 1'b1);
      tick(600);
      chk({15'h0000, burstActive}, 16'h0000);
      chk(16'(nGood - g), 16'h0002);
      $display("test short gap release done");
      eventsPending = 1'b1;
      wr(`RBDC_OFF_RX_CONFIG, 16'h0400);
      autoSwitchNeed = 1'b1;
      waitOn(1, 20);
      mv(1, 1'b1);
      autoSwitchNeed = 1'b0;
      tick(5);
      rd(`RBDC_OFF_DMA_START, 16'h0200);
      rd(`RBDC_OFF_DMA_BCOUNT, 16'h0040);
      chk({15'h0000, dmaActive}, 16'h0001);
      eventsPending = 1'b0;
      tick(5);
      chk({15'h0000, dmaActive}, 16'h0001);
      rd(`RBDC_OFF_DMA_FCOUNT, 16'h0001);
      rd(`RBDC_OFF_DMA_FCOUNT, 16'h0001);
      rd(`RBDC_OFF_DMA_FCOUNT, 16'h0000);
      waitOn(2, 20);
      $display("test auto switch exit done");
      wr(`RBDC_OFF_BUF_CONFIG, 16'h0000);
      wr(`RBDC_OFF_RX_CONFIG, 16'h0200);
      waitOn(1, 20);
      d = nDma;
      mv(1, 1'b0);
      tick(2);
      chk(16'(nDma - d), 16'h0000);
      wr(`RBDC_OFF_BUF_CONFIG, 16'h0080);
      mv(1, 1'b0);
      tick(2);
      chk(16'(nDma - d), 16'h0001);
      $display("test dma only irq enable done");
      summarize();
   end
endmodule : rbdc_tb_top

`default_nettype wire
